// ===== hdl/spds_regs.svh
// Purpose: Timing counts and pin positions for the sensor power-down sequencer.
// Assumes: The sequencer clock runs at 100 MHz.
// Notes:   Definitions only; included by bare name.
`ifndef SPDS_REGS_SVH
`define SPDS_REGS_SVH

// Sequencer clock rate in MHz.
`define SPDS_CLK_MHZ        100
// Clock lane lingers in high speed after the data lanes stop (post plus trail).
`define SPDS_CLK_POST_NS    5000
// Least time, so it rounds up to whole cycles.
`define SPDS_CLK_POST_CYC   ((`SPDS_CLK_POST_NS * `SPDS_CLK_MHZ + 999) / 1000)
// Least sensor clock cycles from the last frame end to hard reset falling.
`define SPDS_RST_GAP_CYC    512
// Width of the cycle counters; must hold both counts above.
`define SPDS_CNT_W          10

// Bit positions of the synchronised pins.
`define SPDS_PIN_RSTN       0
`define SPDS_PIN_SHDN       1
`define SPDS_PIN_CSEL       2
`define SPDS_PIN_REFCLK     3
`define SPDS_PIN_XTAL       4
`define SPDS_PIN_COUNT      5

// Output enable positions of the pins that stay high impedance.
`define SPDS_OE_REFCLK      0
`define SPDS_OE_RSTN        1
`define SPDS_OE_SHDN        2
`define SPDS_OE_SCL         3
`define SPDS_OE_COUNT       4

`endif

// ===== hdl/spds_pkg.sv
// Purpose: Types shared by the sensor power-down sequencer.
// Assumes: Nothing beyond the header of constants.
// Notes:   Lane codes are plain enumeration values (HS 0, LP11 1, LP00 2), not the line pair levels.
`default_nettype none
package spds_pkg;

    typedef enum logic [2:0] {
        SPDS_STREAM    = 3'h0,
        SPDS_DRAIN     = 3'h1,
        SPDS_DATA_STOP = 3'h2,
        SPDS_STANDBY   = 3'h3,
        SPDS_RESET     = 3'h4
    } spds_state_e;

    typedef enum logic [1:0] {
        SPDS_LANE_HS   = 2'h0,
        SPDS_LANE_LP11 = 2'h1,
        SPDS_LANE_LP00 = 2'h2
    } spds_lane_e;

endpackage
`default_nettype wire

// ===== hdl/spds_pin_if.sv
// Purpose: Carries synchronised pin levels and their edges inside the sequencer.
// Assumes: One producer, the pin synchroniser.
// Notes:   Edge bits are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
interface spds_pin_if #(
    parameter int WIDTH = 5
);
    logic [WIDTH-1:0] level;
    logic [WIDTH-1:0] rise;
    logic [WIDTH-1:0] fall;

    modport sync (output level, output rise, output fall);
    modport user (input level, input rise, input fall);
endinterface
`default_nettype wire

// ===== hdl/spds_pin_sync.sv
// Purpose: Two-flop synchroniser with edge detection for asynchronous pins.
// Assumes: Pins change slower than half the sampling clock.
// Notes:   Edges are taken after the second flop, never from the first.
`timescale 1ns/1ps
`default_nettype none
module spds_pin_sync #(
    parameter int WIDTH = 5
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] pins_in,
    spds_pin_if.sync              pins
);
    if (WIDTH < 1) begin : g_bad_width
        $error("spds_pin_sync needs at least one pin");
    end

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] prev;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta   <= '0;
            stable <= '0;
            prev   <= '0;
        end else begin
            meta   <= pins_in;
            stable <= meta;
            prev   <= stable;
        end
    end

    assign pins.level = stable;
    assign pins.rise  = stable & ~prev;
    assign pins.fall  = ~stable & prev;
endmodule
`default_nettype wire

// ===== hdl/spds_sequencer.sv
// Purpose: Streaming to standby sequencing of an image sensor's serial output lanes.
// Assumes: Power-down and stream requests arrive as one-cycle pulses from the control
//          port logic on clk_in; frame and drain status come from the output pipeline.
// Notes:   Reference clock and crystal are sampled, not used as clocks.
`timescale 1ns/1ps
`default_nettype none
`include "spds_regs.svh"

// Behaviour
// RQ1: Host's last command within one frame of end.
// RQ2: Host waits 512 sensor clocks before reset.
// RQ3: Power-down request starts the sequence.
// RQ4: Wait for frame end and drained data.
// RQ5: Data lanes go to LP11 when done.
// RQ6: Clock lane follows about 5 us later.
// RQ7: Lanes hold LP11 until restart or reset.
// RQ8: Select pin high external, low crystal.
// RQ9: External clock square, 12 to 50 MHz; the host model drives 6.25 MHz.
// RQ10: Host drives pins low or open when off.
// RQ11: Clock, reset, shutdown, bus pins stay undriven.
// RQ12: Reference clock pin always high impedance.
// RQ13: Host drops shutdown and clock after reset.
// RQ14: External core supply keeps shutdown low.
module spds_sequencer (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       hard_reset_n_in,
    input  wire logic       regulator_shutdown_ctl_in,
    input  wire logic       clock_source_select_in,
    input  wire logic       ref_clock_pin_in,
    input  wire logic       xtal_clock_in,
    input  wire logic       power_down_req_in,
    input  wire logic       stream_start_in,
    input  wire logic       frame_active_in,
    input  wire logic       data_pending_in,
    input  wire logic       i2c_sda_drive_in,
    output var  logic [1:0] data_lane_out,
    output var  logic [1:0] clk_lane_out,
    output var  logic       streaming_out,
    output var  logic       standby_out,
    output var  logic       clock_source_ext_out,
    output var  logic       core_regulator_on_out,
    output var  logic [3:0] pin_oe_out,
    output var  logic       sda_oe_out,
    output var  logic       reset_early_out
);
    localparam int                 PINS      = `SPDS_PIN_COUNT;
    localparam int                 POST_CYC  = `SPDS_CLK_POST_CYC;
    localparam int                 GAP_CYC   = `SPDS_RST_GAP_CYC;
    localparam logic [`SPDS_CNT_W-1:0] POST_LAST = `SPDS_CNT_W'(`SPDS_CLK_POST_CYC - 1);
    localparam logic [`SPDS_CNT_W-1:0] GAP_MIN   = `SPDS_CNT_W'(`SPDS_RST_GAP_CYC);

    if (POST_CYC > (1 << `SPDS_CNT_W) || GAP_CYC >= (1 << `SPDS_CNT_W)) begin : g_bad_cnt
        $error("spds_sequencer counter too narrow for its timing counts");
    end

    spds_pin_if #(.WIDTH(PINS)) pin_bus ();

    spds_pin_sync #(.WIDTH(PINS)) u_pin_sync (
        .clk_in  (clk_in),
        .rst_in  (rst_in),
        .pins_in ({xtal_clock_in, ref_clock_pin_in, clock_source_select_in,
                   regulator_shutdown_ctl_in, hard_reset_n_in}),
        .pins    (pin_bus.sync)
    );

    spds_pkg::spds_state_e state;
    spds_pkg::spds_state_e next_state;
    logic [`SPDS_CNT_W-1:0] post_cnt;
    logic [`SPDS_CNT_W-1:0] gap_cnt;
    logic                   gap_armed;
    logic [1:0]             next_data_lane;
    logic [1:0]             next_clk_lane;

    wire hard_reset_n_s = pin_bus.level[`SPDS_PIN_RSTN];
    wire reset_fall     = pin_bus.fall[`SPDS_PIN_RSTN];
    wire ext_selected   = pin_bus.level[`SPDS_PIN_CSEL];
    // Sensor clock edges come from whichever source the select pin names.
    wire sensor_edge    = ext_selected ? pin_bus.rise[`SPDS_PIN_REFCLK]   // RQ8
                                       : pin_bus.rise[`SPDS_PIN_XTAL];
    // The frame has ended and the output interface holds none of its data.
    wire frame_done     = !frame_active_in && !data_pending_in;      // RQ4
    wire enter_stop     = (next_state == spds_pkg::SPDS_DATA_STOP) &&
                          (state != spds_pkg::SPDS_DATA_STOP);
    wire post_done      = (post_cnt == POST_LAST);
    wire gap_short      = gap_armed && (gap_cnt < GAP_MIN);
    wire restart        = (state == spds_pkg::SPDS_STANDBY) && stream_start_in &&
                          hard_reset_n_s;

    // A low hard reset pin overrides every state, so the lanes leave LP11 only then or on a restart from standby.
    always_comb begin
        next_state = state;
        if (!hard_reset_n_s) begin
            next_state = spds_pkg::SPDS_RESET;                        // RQ7
        end else begin
            case (state)
                spds_pkg::SPDS_STREAM: begin
                    if (power_down_req_in) begin
                        next_state = spds_pkg::SPDS_DRAIN;            // RQ3
                    end
                end
                spds_pkg::SPDS_DRAIN: begin
                    if (frame_done) begin
                        next_state = spds_pkg::SPDS_DATA_STOP;        // RQ4
                    end
                end
                spds_pkg::SPDS_DATA_STOP: begin
                    if (post_done) begin
                        next_state = spds_pkg::SPDS_STANDBY;          // RQ6
                    end
                end
                spds_pkg::SPDS_STANDBY: begin
                    if (stream_start_in) begin
                        next_state = spds_pkg::SPDS_STREAM;           // RQ7
                    end
                end
                spds_pkg::SPDS_RESET: begin
                    next_state = spds_pkg::SPDS_STANDBY;
                end
                default: begin
                    next_state = spds_pkg::SPDS_RESET;
                end
            endcase
        end
    end

    // Data lanes stop as soon as the drain ends; the clock lane keeps running
    // through the post and trail interval so the receiver can close the burst.
    assign next_data_lane = (next_state == spds_pkg::SPDS_RESET) ? spds_pkg::SPDS_LANE_LP00 :
                            (next_state == spds_pkg::SPDS_STREAM ||
                             next_state == spds_pkg::SPDS_DRAIN)  ? spds_pkg::SPDS_LANE_HS // RQ5
                                                                  : spds_pkg::SPDS_LANE_LP11;
    assign next_clk_lane  = (next_state == spds_pkg::SPDS_RESET)   ? spds_pkg::SPDS_LANE_LP00 :
                            (next_state == spds_pkg::SPDS_STANDBY) ? spds_pkg::SPDS_LANE_LP11
                                                                   : spds_pkg::SPDS_LANE_HS; // RQ6

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state         <= spds_pkg::SPDS_RESET;
            data_lane_out <= spds_pkg::SPDS_LANE_LP00;
            clk_lane_out  <= spds_pkg::SPDS_LANE_LP00;
            streaming_out <= 1'b0;
            standby_out   <= 1'b0;
        end else begin
            state         <= next_state;
            data_lane_out <= next_data_lane;
            clk_lane_out  <= next_clk_lane;
            streaming_out <= (next_state == spds_pkg::SPDS_STREAM);
            standby_out   <= (next_state == spds_pkg::SPDS_STANDBY);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            post_cnt <= '0;
        end else if (state == spds_pkg::SPDS_DATA_STOP && !post_done) begin
            post_cnt <= post_cnt + 1'b1;                              // RQ6
        end else begin
            post_cnt <= '0;
        end
    end

    // The host's reset gap is counted in sensor clocks from the last frame end.
    // A short gap is only reported; the device cannot refuse the reset pin.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            gap_cnt   <= '0;
            gap_armed <= 1'b0;
        end else if (enter_stop) begin
            gap_cnt   <= '0;
            gap_armed <= 1'b1;
        end else if (reset_fall || restart) begin
            gap_armed <= 1'b0;
        end else if (sensor_edge && gap_cnt < GAP_MIN) begin
            gap_cnt   <= gap_cnt + 1'b1;                              // RQ2
        end
    end

    // The flag is set by the early edge and cleared by a restart; set wins.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            reset_early_out <= 1'b0;
        end else if (reset_fall && gap_short) begin
            reset_early_out <= 1'b1;                                  // RQ2
        end else if (restart) begin
            reset_early_out <= 1'b0;
        end
    end

    // Reference clock, reset, shutdown and clock line are inputs only; the data
    // line is released whenever the part is held in reset.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            clock_source_ext_out  <= 1'b0;
            core_regulator_on_out <= 1'b0;
            pin_oe_out            <= '0;
            sda_oe_out            <= 1'b0;
        end else begin
            clock_source_ext_out  <= ext_selected;                                  // RQ8
            core_regulator_on_out <= pin_bus.level[`SPDS_PIN_SHDN];                 // RQ14
            pin_oe_out            <= '0;                                            // RQ11 RQ12
            sda_oe_out            <= i2c_sda_drive_in && hard_reset_n_s;            // RQ11
        end
    end

    // Helper that counts how long the clock lane outlives the data lanes.
    logic [`SPDS_CNT_W-1:0] clk_wait;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            clk_wait <= '0;
        end else if (data_lane_out == spds_pkg::SPDS_LANE_LP11 &&
                     clk_lane_out == spds_pkg::SPDS_LANE_HS) begin
            clk_wait <= clk_wait + 1'b1;
        end else begin
            clk_wait <= '0;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_pd_accept;
        state == spds_pkg::SPDS_STREAM && power_down_req_in && hard_reset_n_s;
    endsequence

    sequence s_data_stopped;
        $rose(data_lane_out == spds_pkg::SPDS_LANE_LP11) &&
        $past(data_lane_out) == spds_pkg::SPDS_LANE_HS;
    endsequence

    sequence s_clk_stopped;
        $rose(clk_lane_out == spds_pkg::SPDS_LANE_LP11) && $past(hard_reset_n_s);
    endsequence

    request_to_drain_a: assert property (s_pd_accept |=> state == spds_pkg::SPDS_DRAIN ##1 // RQ3
                                         data_lane_out == spds_pkg::SPDS_LANE_HS
                                         or !hard_reset_n_s || frame_done)
        else $error("power-down request did not start the drain");

    drain_wait_a: assert property (s_data_stopped |-> $past(frame_done)) // RQ4
        else $error("data lanes stopped before the frame was drained");

    data_lane_stop_a: assert property (state == spds_pkg::SPDS_DATA_STOP |-> // RQ5
                                       data_lane_out == spds_pkg::SPDS_LANE_LP11 &&
                                       clk_lane_out == spds_pkg::SPDS_LANE_HS)
        else $error("lanes wrong while the clock lane trails");

    clock_trail_a: assert property (s_clk_stopped and ##0 $past(data_lane_out) == // RQ6
                                    spds_pkg::SPDS_LANE_LP11 |-> $past(clk_wait) == POST_CYC - 1)
        else $error("clock lane trail length is wrong");

    lane_hold_a: assert property (state == spds_pkg::SPDS_STANDBY && hard_reset_n_s && // RQ7
                                  !stream_start_in |=> data_lane_out == spds_pkg::SPDS_LANE_LP11 &&
                                  clk_lane_out == spds_pkg::SPDS_LANE_LP11)
        else $error("lanes left the stop state without restart or reset");

    source_select_a: assert property ($changed(clock_source_select_in) |-> ##3 // RQ8
                                      clock_source_ext_out == $past(clock_source_select_in, 3)
                                      or $changed($past(clock_source_select_in)))
        else $error("clock source select did not follow the pin");

    pins_undriven_a: assert property (!hard_reset_n_s |=> !sda_oe_out && // RQ11
                                      data_lane_out == spds_pkg::SPDS_LANE_LP00)
        else $error("device drove a pin while held in reset");

    refclk_hiz_a: assert property (pin_oe_out[`SPDS_OE_REFCLK] == 1'b0 && // RQ12
                                   pin_oe_out[`SPDS_OE_RSTN] == 1'b0)
        else $error("reference clock or reset pin was driven");
endmodule
`default_nettype wire

// ===== tb/spds_host_model.sv
// Purpose: Companion host that drives the sensor's reset, shutdown, select and clock pins.
// Assumes: Pins are asynchronous to the sequencer clock; reference clock period 160 ns.
// Notes:   Sensor clock cycles are counted on whichever source the select pin picks.
`timescale 1ns/1ps
`default_nettype none
module spds_host_model (
    output var logic hard_reset_n_out,
    output var logic shutdown_out,
    output var logic select_out,
    output var logic ref_clock_out,
    output var logic xtal_clock_out
);
    logic run;

    initial begin
        hard_reset_n_out = 1'b0;
        shutdown_out     = 1'b0;
        select_out       = 1'b1;
        ref_clock_out    = 1'b0;
        xtal_clock_out   = 1'b0;
        run              = 1'b0;
    end

    // Square wave of 160 ns period; the 3 ns offset keeps its edges off the sampling edge.
    initial begin
        #3;
        forever begin
            #80;
            ref_clock_out = run ? ~ref_clock_out : 1'b0;
        end
    end

    initial begin
        #7;
        forever begin
            #20;
            xtal_clock_out = run ? ~xtal_clock_out : 1'b0;
        end
    end

    task automatic set_select(input logic ext);
        select_out = ext;
    endtask

    // Callers may sit on a sequencer clock edge, so the pins move a little later.
    task automatic power_on();
        #2;
        shutdown_out = 1'b1;
        run = 1'b1;
        repeat (4) @(posedge ref_clock_out);
        hard_reset_n_out = 1'b1;
    endtask

    // A gap below 512 is only ever asked for on purpose, to see the early flag.
    task automatic power_off(input int gap);
        repeat (gap) @(posedge (select_out ? ref_clock_out : xtal_clock_out));
        hard_reset_n_out = 1'b0;
        #100;
        shutdown_out = 1'b0;
        run = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: Self-checking bench for the sensor power-down sequencer.
// Assumes: 100 MHz sequencer clock; host model drives the asynchronous pins.
// Notes:   Expected lane states live in integer model variables updated per step.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_in, rst_in, rstn, shdn, csel, refclk, xtal;
    logic pd_req, start, frame_act, pending, sda_drv;
    logic [1:0] data_lane_out, clk_lane_out;
    logic streaming_out, standby_out, ext_out, reg_on_out, sda_oe_out, early_out;
    logic [3:0] pin_oe_out;
    int   n_errors, n_tests, m_data, m_clk, m_stream, m_standby;

    spds_host_model u_host (.hard_reset_n_out(rstn), .shutdown_out(shdn),
        .select_out(csel), .ref_clock_out(refclk), .xtal_clock_out(xtal));

    spds_sequencer u_dut (.clk_in(clk_in), .rst_in(rst_in), .hard_reset_n_in(rstn),
        .regulator_shutdown_ctl_in(shdn), .clock_source_select_in(csel),
        .ref_clock_pin_in(refclk), .xtal_clock_in(xtal), .power_down_req_in(pd_req),
        .stream_start_in(start), .frame_active_in(frame_act), .data_pending_in(pending),
        .i2c_sda_drive_in(sda_drv), .data_lane_out(data_lane_out),
        .clk_lane_out(clk_lane_out), .streaming_out(streaming_out),
        .standby_out(standby_out), .clock_source_ext_out(ext_out),
        .core_regulator_on_out(reg_on_out), .pin_oe_out(pin_oe_out),
        .sda_oe_out(sda_oe_out), .reset_early_out(early_out));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    task automatic final_report();
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_in);
            #1;
        end
    endtask

    // Waits a bounded number of cycles for the data lane or standby to reach a value.
    task automatic wait_for(input bit on_standby, input logic [1:0] want, input int limit);
        int i;
        i = 0;
        while ((on_standby ? {1'b0, standby_out} : data_lane_out) !== want && i < limit) begin
            tick(1);
            i++;
        end
        if ((on_standby ? {1'b0, standby_out} : data_lane_out) !== want) begin
            n_errors++;
            final_report();
        end
    endtask

    task automatic pulse(input bit is_start);
        @(posedge clk_in);
        if (is_start) start <= 1'b1;
        else pd_req <= 1'b1;
        @(posedge clk_in);
        start <= 1'b0;
        pd_req <= 1'b0;
        #1;
    endtask

    task automatic chk_model();
        check(4'(data_lane_out), 4'(m_data));
        check(4'(clk_lane_out), 4'(m_clk));
        check(4'(streaming_out), 4'(m_stream));
        check(4'(standby_out), 4'(m_standby));
        check(pin_oe_out, 4'h0);
    endtask

    task automatic set_lanes(input int lane, input int strm, input int stby);
        m_data = lane;
        m_clk = lane;
        m_stream = strm;
        m_standby = stby;
    endtask

    initial begin
        {pd_req, start, frame_act, pending, sda_drv} = 5'h00;
        n_errors = 0;
        n_tests = 0;
        rst_in = 1'b1;
        void'($urandom(32'h2ebeeb3a));
        repeat (4) @(posedge clk_in);
        rst_in <= 1'b0;
        u_host.power_on();
        wait_for(1'b1, 2'h1, 40);
        set_lanes(spds_pkg::SPDS_LANE_LP11, 0, 1);
        chk_model();
        check(4'(reg_on_out), 4'h1);
        for (int s = 0; s < 2; s++) begin
            u_host.set_select(s[0]);
            tick(4);
            check(4'(ext_out), 4'(s));
        end
        pulse(1'b0);
        tick(3);
        chk_model();
        for (int k = 0; k < 2; k++) begin
            u_host.set_select(k == 0);
            tick(4);
            @(posedge clk_in);
            frame_act <= 1'b1;
            pending <= 1'b1;
            pulse(1'b1);
            tick(1);
            set_lanes(spds_pkg::SPDS_LANE_HS, 1, 0);
            chk_model();
            check(4'(early_out), 4'h0);
            tick(5 + $urandom % 26);
            pulse(1'b0);
            tick(1);
            m_stream = 0;
            chk_model();
            tick(2 + $urandom % 39);
            @(posedge clk_in);
            frame_act <= 1'b0;
            tick(2 + $urandom % 19);
            chk_model();
            @(posedge clk_in);
            pending <= 1'b0;
            tick(1);
            m_data = spds_pkg::SPDS_LANE_LP11;
            chk_model();
            tick(499);
            chk_model();
            tick(1);
            set_lanes(spds_pkg::SPDS_LANE_LP11, 0, 1);
            chk_model();
            pulse(1'b0);
            tick(20);
            chk_model();
            @(posedge clk_in);
            sda_drv <= 1'b1;
            tick(2);
            check(4'(sda_oe_out), 4'h1);
            u_host.power_off(k == 0 ? 520 : 10);
            wait_for(1'b0, 2'h2, 8);
            set_lanes(spds_pkg::SPDS_LANE_LP00, 0, 0);
            chk_model();
            check(4'(early_out), 4'(k));
            check(4'(sda_oe_out), 4'h0);
            tick(5);
            check(4'(reg_on_out), 4'h0);
            @(posedge clk_in);
            sda_drv <= 1'b0;
            u_host.power_on();
            wait_for(1'b1, 2'h1, 40);
            set_lanes(spds_pkg::SPDS_LANE_LP11, 0, 1);
            chk_model();
            check(4'(early_out), 4'(k));
        end
        pulse(1'b1);
        tick(1);
        check(4'(early_out), 4'h0);
        check(4'(streaming_out), 4'h1);
        final_report();
    end
endmodule
`default_nettype wire
